/* rtl/fpcd_pkg.sv */
// Package of constants for the flash protection command host controller
package fpcd_pkg;
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	localparam int SECT_LSB = 16;
	localparam logic [11:0] UNLOCK_A1 = 12'h0555;
	localparam logic [11:0] UNLOCK_A2 = 12'h02AA;
	localparam logic [7:0] UNLOCK_D1 = 8'hAA;
	localparam logic [7:0] UNLOCK_D2 = 8'h55;
	localparam logic [7:0] CMD_FREEZE_ENTRY = 8'h50;
	localparam logic [7:0] CMD_VOLATILE_ENTRY = 8'hE0;
	localparam logic [7:0] CMD_ECC_ENTRY = 8'h75;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_EXIT = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] GUARD_SET_DATA = 8'h00;
	localparam logic [7:0] GUARD_CLEAR_DATA = 8'h01;
	localparam logic [7:0] EXIT_DATA = 8'h00;
	localparam logic [7:0] PROTECTED_CODE = 8'h00;
	localparam logic [7:0] UNPROTECTED_CODE = 8'h01;
	localparam int FAIL_BIT = 5;
	// Register offsets of the controller's own port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_RDATA = 4'h3;
	// Operation codes written to the control register
	localparam logic [3:0] OP_FREEZE_CLEAR = 4'h1;
	localparam logic [3:0] OP_FREEZE_READ = 4'h2;
	localparam logic [3:0] OP_GUARD_SET = 4'h3;
	localparam logic [3:0] OP_GUARD_CLEAR = 4'h4;
	localparam logic [3:0] OP_GUARD_READ = 4'h5;
	localparam logic [3:0] OP_ECC_READ = 4'h6;
	localparam logic [3:0] OP_ARRAY_READ = 4'h7;
	localparam logic [3:0] OP_RESET = 4'h8;
	// Bus cycle timing, given in ns and rounded up to whole clk cycles
	localparam int CLK_NS = 20;
	localparam int WE_LOW_NS = 60;
	localparam int READ_ACC_NS = 120;
	localparam int WE_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC = (READ_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] WE_CNT = 4'(WE_CYC);
	localparam logic [3:0] RD_CNT = 4'(RD_CYC);
	typedef enum logic [1:0] {CYC_WRITE, CYC_READ} fpcd_cyc_type;
endpackage : fpcd_pkg

/* rtl/fpcd_cyc_if.sv */
// Interface between the sequencer and the bus cycle engine
`timescale 1ns/1ns
`default_nettype none
interface fpcd_cyc_if;
	logic req;
	logic rd;
	logic [25:0] addr;
	logic [15:0] wdata;
	logic done;
	logic [15:0] rdata;
	modport seq (output req, rd, addr, wdata, input done, rdata);
	modport eng (input req, rd, addr, wdata, output done, rdata);
endinterface : fpcd_cyc_if
`default_nettype wire

/* rtl/fpcd_cycle.sv */
// Bus cycle engine: one write or read cycle on the flash pins
`timescale 1ns/1ns
`default_nettype none
module fpcd_cycle (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Sequencer side
	fpcd_cyc_if.eng cyc,
	// Flash pins
	output logic [fpcd_pkg::ADDR_W-1:0] addr_o,
	output logic [fpcd_pkg::DATA_W-1:0] dq_out_o,
	output logic dq_oe_o,
	input wire logic [fpcd_pkg::DATA_W-1:0] dq_in_i,
	output logic ce_n_o,
	output logic oe_n_o,
	output logic we_n_o
);
	import fpcd_pkg::*;
	logic [15:0] dq_s1, dq_s2;
	logic busy, next_busy, is_rd, next_is_rd;
	logic [3:0] cnt, next_cnt;
	logic [25:0] next_addr;
	logic [15:0] next_dq, rdata, next_rdata;
	logic done, next_done;
	always_comb begin
		next_busy = busy;
		next_is_rd = is_rd;
		next_cnt = cnt;
		next_addr = addr_o;
		next_dq = dq_out_o;
		next_rdata = rdata;
		next_done = 1'b0;
		if (!busy && cyc.req) begin
			next_busy = 1'b1;
			next_is_rd = cyc.rd;
			next_addr = cyc.addr;
			next_dq = cyc.wdata;
			next_cnt = cyc.rd ? RD_CNT : WE_CNT;
		end else if (busy) begin
			if (cnt != 4'h0) begin
				next_cnt = cnt - 4'h1;
			end else begin
				next_busy = 1'b0;
				next_done = 1'b1;
				if (is_rd) begin
					next_rdata = dq_s2;
				end
			end
		end
	end
	always_ff @(posedge clk_i) begin
		dq_s1 <= dq_in_i;
		dq_s2 <= dq_s1;
		if (!nrst_i) begin
			busy <= 1'b0;
			is_rd <= 1'b0;
			cnt <= 4'h0;
			addr_o <= '0;
			dq_out_o <= '0;
			rdata <= '0;
			done <= 1'b0;
		end else begin
			busy <= next_busy;
			is_rd <= next_is_rd;
			cnt <= next_cnt;
			addr_o <= next_addr;
			dq_out_o <= next_dq;
			rdata <= next_rdata;
			done <= next_done;
		end
	end
	assign ce_n_o = !busy;
	assign we_n_o = !(busy && !is_rd && cnt != 4'h0);
	assign oe_n_o = !(busy && is_rd);
	assign dq_oe_o = busy && !is_rd;
	assign cyc.done = done;
	assign cyc.rdata = rdata;
endmodule : fpcd_cycle
`default_nettype wire

/* rtl/fpcd_host.sv */
// Host controller driving protection and ECC command sequences
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module fpcd_host (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Flash pins
	output logic [fpcd_pkg::ADDR_W-1:0] addr_o,
	output logic [fpcd_pkg::DATA_W-1:0] dq_out_o,
	output logic dq_oe_o,
	input wire logic [fpcd_pkg::DATA_W-1:0] dq_in_i,
	output logic ce_n_o,
	output logic oe_n_o,
	output logic we_n_o
);
	import fpcd_pkg::*;
	typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} fpcd_state_type;
	fpcd_cyc_if cyc ();
	fpcd_state_type state, next_state;
	logic [3:0] op, next_op, step, next_step, nsteps;
	logic [25:0] target, next_target;
	logic [15:0] result, next_result;
	logic fail, next_fail, protect, next_protect;
	logic [25:0] c_addr;
	logic [15:0] c_data;
	logic c_rd;
	function automatic logic [25:0] sect_addr(input logic [25:0] a);
		sect_addr = {a[25:SECT_LSB], 16'h0000};
	endfunction : sect_addr
	function automatic logic [25:0] cmd_addr(input logic [11:0] a);
		cmd_addr = {14'h0000, a};
	endfunction : cmd_addr
	function automatic logic [15:0] cmd_data(input logic [7:0] d);
		cmd_data = {8'h00, d};
	endfunction : cmd_data
	// Cycle table: operation and step select address, data and direction
	always_comb begin
		c_addr = '0;
		c_data = '0;
		c_rd = 1'b0;
		nsteps = 4'h1;
		if (op == OP_ARRAY_READ) begin
			c_addr = target;
			c_rd = 1'b1;
		end else if (op == OP_RESET) begin
			c_data = cmd_data(CMD_RESET);
		end else begin
			unique case (step)
				4'h0: begin
					c_addr = cmd_addr(UNLOCK_A1);
					c_data = cmd_data(UNLOCK_D1);
				end
				4'h1: begin
					c_addr = cmd_addr(UNLOCK_A2);
					c_data = cmd_data(UNLOCK_D2);
				end
				4'h2: begin
					c_addr = cmd_addr(UNLOCK_A1);
					if (op == OP_FREEZE_CLEAR || op == OP_FREEZE_READ) begin
						c_data = cmd_data(CMD_FREEZE_ENTRY);
					end else if (op == OP_ECC_READ) begin
						c_data = cmd_data(CMD_ECC_ENTRY);
					end else begin
						c_data = cmd_data(CMD_VOLATILE_ENTRY);
					end
				end
				4'h3: begin
					if (op == OP_FREEZE_READ) begin
						c_rd = 1'b1;
					end else if (op == OP_GUARD_READ) begin
						c_addr = sect_addr(target);
						c_rd = 1'b1;
					end else if (op == OP_ECC_READ) begin
						c_addr = target;
						c_rd = 1'b1;
					end else begin
						c_data = cmd_data(CMD_PROGRAM);
					end
				end
				4'h4: begin
					if (op == OP_ECC_READ) begin
						c_data = cmd_data(CMD_RESET);
					end else if (op == OP_FREEZE_CLEAR) begin
						c_data = cmd_data(8'h00);
					end else if (op == OP_GUARD_SET) begin
						c_addr = sect_addr(target);
						c_data = cmd_data(GUARD_SET_DATA);
					end else if (op == OP_GUARD_CLEAR) begin
						c_addr = sect_addr(target);
						c_data = cmd_data(GUARD_CLEAR_DATA);
					end else begin
						c_data = cmd_data(CMD_EXIT);
					end
				end
				4'h5: begin
					if (op == OP_FREEZE_READ || op == OP_GUARD_READ) begin
						c_data = cmd_data(EXIT_DATA);
					end else begin
						c_data = cmd_data(CMD_EXIT);
					end
				end
				default: begin
					c_data = cmd_data(EXIT_DATA);
				end
			endcase
			if (op == OP_ECC_READ) begin
				nsteps = 4'h5;
			end else if (op == OP_FREEZE_READ || op == OP_GUARD_READ) begin
				nsteps = 4'h6;
			end else begin
				nsteps = 4'h7;
			end
		end
	end
	assign cyc.req = (state == S_ISSUE);
	assign cyc.rd = c_rd;
	assign cyc.addr = c_addr;
	assign cyc.wdata = c_data;
	always_comb begin
		next_state = state;
		next_op = op;
		next_step = step;
		next_target = target;
		next_result = result;
		next_fail = fail;
		next_protect = protect;
		unique case (state)
			S_IDLE: begin
				if (reg_wr_i && reg_addr_i == REG_ADDR) begin
					next_target = reg_wdata_i[25:0];
				end
				if (reg_wr_i && reg_addr_i == REG_CTRL &&
				    reg_wdata_i[3:0] >= OP_FREEZE_CLEAR &&
				    reg_wdata_i[3:0] <= OP_RESET) begin
					next_op = reg_wdata_i[3:0];
					next_step = 4'h0;
					next_state = S_ISSUE;
				end
			end
			S_ISSUE: begin
				next_state = S_WAIT;
			end
			S_WAIT: begin
				if (cyc.done) begin
					if (c_rd) begin
						next_result = cyc.rdata;
						next_protect = (cyc.rdata[7:0] == PROTECTED_CODE);
						next_fail = cyc.rdata[FAIL_BIT];
					end
					if (step + 4'h1 >= nsteps) begin
						next_state = S_IDLE;
					end else begin
						next_step = step + 4'h1;
						next_state = S_ISSUE;
					end
				end
			end
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state <= S_IDLE;
			op <= 4'h0;
			step <= 4'h0;
			target <= '0;
			result <= '0;
			fail <= 1'b0;
			protect <= 1'b0;
		end else begin
			state <= next_state;
			op <= next_op;
			step <= next_step;
			target <= next_target;
			result <= next_result;
			fail <= next_fail;
			protect <= next_protect;
		end
	end
	// Register read data, one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_ADDR: reg_rdata_o <= {6'h00, target};
				REG_STATUS: reg_rdata_o <= {29'h0, fail, protect,
				    state != S_IDLE};
				REG_RDATA: reg_rdata_o <= {16'h0000, result};
				REG_CTRL: reg_rdata_o <= {28'h0, op};
				default: reg_rdata_o <= '0;
			endcase
		end else begin
			reg_rdata_o <= '0;
		end
	end
	fpcd_cycle u_cycle (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.cyc(cyc.eng),
		.addr_o(addr_o),
		.dq_out_o(dq_out_o),
		.dq_oe_o(dq_oe_o),
		.dq_in_i(dq_in_i),
		.ce_n_o(ce_n_o),
		.oe_n_o(oe_n_o),
		.we_n_o(we_n_o)
	);
	property p_fc_entry;
		@(posedge clk_i) disable iff (!nrst_i)
		(state == S_ISSUE && op == OP_FREEZE_CLEAR && step == 4'h2)
		|-> cyc.wdata == 16'h0050 && cyc.addr == 26'h000_0555;
	endproperty
	a_fc_entry: assert property (p_fc_entry) else $error("bad freeze entry");
	property p_sect;
		@(posedge clk_i) disable iff (!nrst_i)
		(state == S_ISSUE && op == OP_GUARD_SET && step == 4'h4)
		|-> cyc.addr[15:0] == 16'h0000 && cyc.wdata == 16'h0000;
	endproperty
	a_sect: assert property (p_sect) else $error("bad sector set");
	property p_exit;
		@(posedge clk_i) disable iff (!nrst_i)
		(state == S_ISSUE && op == OP_GUARD_CLEAR && step == 4'h5)
		|-> cyc.wdata == 16'h0090 && !cyc.rd;
	endproperty
	a_exit: assert property (p_exit) else $error("bad exit");
	property p_hi;
		@(posedge clk_i) disable iff (!nrst_i)
		(state == S_ISSUE && !cyc.rd) |-> cyc.wdata[15:8] == 8'h00;
	endproperty
	a_hi: assert property (p_hi) else $error("upper byte set");
	property p_busy;
		@(posedge clk_i) disable iff (!nrst_i)
		(state == S_ISSUE) |=> !ce_n_o;
	endproperty
	a_busy: assert property (p_busy) else $error("no cycle");
	property p_ecc;
		@(posedge clk_i) disable iff (!nrst_i)
		(state == S_ISSUE && op == OP_ECC_READ && step == 4'h4)
		|-> cyc.wdata == 16'h00F0;
	endproperty
	a_ecc: assert property (p_ecc) else $error("no ecc leave");
	property p_rdread;
		@(posedge clk_i) disable iff (!nrst_i)
		(state == S_ISSUE && cyc.rd) |=> !oe_n_o && we_n_o;
	endproperty
	a_rdread: assert property (p_rdread) else $error("read bad");
	property p_prot;
		@(posedge clk_i) disable iff (!nrst_i)
		(state == S_WAIT && cyc.done && c_rd && cyc.rdata[7:0] == 8'h01)
		|=> !protect;
	endproperty
	a_prot: assert property (p_prot) else $error("status code");
endmodule : fpcd_host
`default_nettype wire

/* bench/fpcd_flash_model.sv */
// Behavioural flash device answering protection and ECC command sets
`timescale 1ns/1ns
`default_nettype none
module fpcd_flash_model (
	// Flash pins
	input wire logic [fpcd_pkg::ADDR_W-1:0] addr_i,
	input wire logic [fpcd_pkg::DATA_W-1:0] dq_i,
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	output logic [fpcd_pkg::DATA_W-1:0] dq_o,
	// Observation
	output logic [1:0] mode_o,
	output logic [7:0] bad_o,
	output logic [7:0] wr_cnt_o
);
	import fpcd_pkg::*;
	localparam int NSECT = 2 ** (ADDR_W - SECT_LSB);
	logic [1:0] stage = 2'd0;
	logic prog = 1'b0;
	logic leave = 1'b0;
	logic [7:0] bad_rd = 8'h00;
	logic [7:0] bad_wr = 8'h00;
	logic frozen = 1'b1;
	logic guard [0:NSECT-1];
	logic [DATA_W-1:0] last = 16'h0000;
	logic [DATA_W-1:0] val;
	logic [10:0] a;
	logic [7:0] d;
	logic [ADDR_W-SECT_LSB-1:0] sect;
	initial begin
		mode_o = 2'd0;
		wr_cnt_o = 8'h00;
		for (int i = 0; i < NSECT; i++) begin
			guard[i] = 1'b0;
		end
	end
	assign bad_o = bad_rd + bad_wr;
	assign a = addr_i[10:0];
	assign d = dq_i[7:0];
	assign sect = addr_i[ADDR_W-1:SECT_LSB];
	always_comb begin
		case (mode_o)
			2'd1: val = {15'h0000, !frozen};
			2'd2: val = {15'h0000, !guard[sect]};
			2'd3: val = {8'h00, addr_i[7:0] ^ 8'h3C};
			default: val = addr_i[15:0] ^ 16'hA5C3;
		endcase
	end
	// Released bus shows the inverse of the last word
	assign dq_o = (!ce_n_i && !oe_n_i) ? val : ~last;
	always @(posedge oe_n_i) begin
		last <= val;
	end
	// A read in the middle of a command sequence is a fault
	always @(negedge oe_n_i) begin
		if (!ce_n_i && (stage != 2'd0 || prog || leave)) begin
			bad_rd <= bad_rd + 8'h01;
		end
	end
	always @(posedge we_n_i) begin
		if (!ce_n_i) begin
			wr_cnt_o <= wr_cnt_o + 8'h01;
			if (prog) begin
				prog <= 1'b0;
				if (mode_o == 2'd1 && d == 8'h00) begin
					frozen <= 1'b0;
				end else if (mode_o == 2'd2 && d <= 8'h01) begin
					guard[sect] <= !d[0];
				end else begin
					bad_wr <= bad_wr + 8'h01;
				end
			end else if (leave) begin
				leave <= 1'b0;
				if (d == EXIT_DATA) begin
					mode_o <= 2'd0;
				end else begin
					bad_wr <= bad_wr + 8'h01;
				end
			end else if (stage == 2'd0 && d == CMD_RESET) begin
				mode_o <= 2'd0;
			end else if (stage == 2'd0 && mode_o == 2'd0 && a == UNLOCK_A1[10:0]
				&& d == UNLOCK_D1) begin
				stage <= 2'd1;
			end else if (stage == 2'd1 && a == UNLOCK_A2[10:0] && d == UNLOCK_D2) begin
				stage <= 2'd2;
			end else if (stage == 2'd2 && a == UNLOCK_A1[10:0] && d inside
				{CMD_FREEZE_ENTRY, CMD_VOLATILE_ENTRY, CMD_ECC_ENTRY}) begin
				stage <= 2'd0;
				mode_o <= (d == CMD_FREEZE_ENTRY) ? 2'd1 :
					(d == CMD_ECC_ENTRY) ? 2'd3 : 2'd2;
			end else if (stage == 2'd0 && mode_o inside {2'd1, 2'd2} && d == CMD_PROGRAM) begin
				prog <= 1'b1;
			end else if (stage == 2'd0 && mode_o inside {2'd1, 2'd2} && d == CMD_EXIT) begin
				leave <= 1'b1;
			end else begin
				stage <= 2'd0;
				bad_wr <= bad_wr + 8'h01;
			end
		end
	end
endmodule : fpcd_flash_model
`default_nettype wire

/* bench/tb_top.sv */
// Testbench of the flash protection command host controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import fpcd_pkg::*;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [ADDR_W-1:0] addr_o;
	logic [DATA_W-1:0] dq_out_o;
	logic [DATA_W-1:0] dq_mem;
	logic [DATA_W-1:0] dq_wire;
	logic dq_oe_o, ce_n_o, oe_n_o, we_n_o;
	logic [1:0] mode;
	logic [7:0] bad, wr_cnt;
	logic [31:0] rd_val;
	int error_cnt = 0;
	int checked = 0;
	always #10 clk_i = ~clk_i;
	assign dq_wire = dq_oe_o ? dq_out_o : dq_mem;
	fpcd_host dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .addr_o(addr_o), .dq_out_o(dq_out_o),
		.dq_oe_o(dq_oe_o), .dq_in_i(dq_wire), .ce_n_o(ce_n_o),
		.oe_n_o(oe_n_o), .we_n_o(we_n_o));
	fpcd_flash_model flash (.addr_i(addr_o), .dq_i(dq_wire), .ce_n_i(ce_n_o),
		.oe_n_i(oe_n_o), .we_n_i(we_n_o), .dq_o(dq_mem), .mode_o(mode),
		.bad_o(bad), .wr_cnt_o(wr_cnt));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test
	task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 rd_val = reg_rdata_o;
	endtask : reg_read
	// Runs one operation and judges the write count and final device state
	task automatic do_op(input logic [3:0] op, input logic [31:0] a, input int nwr);
		logic [7:0] w0;
		int n;
		w0 = wr_cnt;
		reg_write(REG_ADDR, a);
		reg_write(REG_CTRL, {28'h000_0000, op});
		repeat (2) @(posedge clk_i);
		n = 0;
		rd_val = 32'h0000_0001;
		while (rd_val[0] !== 1'b0 && n < 300) begin
			reg_read(REG_STATUS);
			n++;
		end
		check("busy", 32'h0, {31'h0, rd_val[0]});
		check("write cycles", nwr, 32'(wr_cnt - w0));
		check("device mode", 32'h0, {30'h0, mode});
		check("device faults", 32'h0, {24'h0, bad});
	endtask : do_op
	task automatic t_reset;
		check("idle pins", 32'h7, {29'h0, ce_n_o, oe_n_o, we_n_o});
		check("dq enable", 32'h0, {31'h0, dq_oe_o});
		check("read data", 32'h0, reg_rdata_o);
		$display("test reset done");
	endtask : t_reset
	task automatic t_array;
		logic [ADDR_W-1:0] al [2] = '{26'h000_0020, 26'h001_2345};
		logic [15:0] e;
		foreach (al[i]) begin
			e = al[i][15:0] ^ 16'hA5C3;
			do_op(OP_ARRAY_READ, 32'(al[i]), 0);
			reg_read(REG_RDATA);
			check("array word", 32'(e), {16'h0, rd_val[15:0]});
			reg_read(REG_STATUS);
			check("failure flag", 32'(e[FAIL_BIT]), {31'h0, rd_val[2]});
		end
		$display("test array done");
	endtask : t_array
	task automatic guard_read(input logic [31:0] a, input logic [7:0] e);
		do_op(OP_GUARD_READ, a, 5);
		reg_read(REG_RDATA);
		check("guard status", 32'(e), {24'h0, rd_val[7:0]});
		reg_read(REG_STATUS);
		check("protected flag", 32'(e == PROTECTED_CODE), {31'h0, rd_val[1]});
	endtask : guard_read
	task automatic t_guard;
		do_op(OP_GUARD_SET, 32'h0030_ABCD, 7);
		guard_read(32'h0030_1234, PROTECTED_CODE);
		guard_read(32'h0041_1234, UNPROTECTED_CODE);
		do_op(OP_GUARD_CLEAR, 32'h0030_0001, 7);
		guard_read(32'h0030_0000, UNPROTECTED_CODE);
		$display("test guard done");
	endtask : t_guard
	task automatic t_freeze;
		do_op(OP_FREEZE_READ, 32'h0000_0000, 5);
		reg_read(REG_RDATA);
		check("freeze before", 32'(PROTECTED_CODE), {24'h0, rd_val[7:0]});
		do_op(OP_FREEZE_CLEAR, 32'h0000_0000, 7);
		do_op(OP_FREEZE_READ, 32'h0123_4567, 5);
		reg_read(REG_RDATA);
		check("freeze after", 32'(UNPROTECTED_CODE), {24'h0, rd_val[7:0]});
		$display("test freeze done");
	endtask : t_freeze
	task automatic t_ecc_reset;
		do_op(OP_ECC_READ, 32'h0000_00A7, 4);
		reg_read(REG_RDATA);
		check("ecc status", 32'h0000_009B, {16'h0, rd_val[15:0]});
		do_op(OP_RESET, 32'h0000_0000, 1);
		$display("test ecc and reset done");
	endtask : t_ecc_reset
	task automatic t_refuse;
		logic [7:0] w0;
		w0 = wr_cnt;
		reg_write(REG_CTRL, 32'h0000_0000);
		reg_write(REG_CTRL, 32'h0000_0009);
		reg_read(REG_STATUS);
		check("busy on bad op", 32'h0, {31'h0, rd_val[0]});
		check("bad op cycles", 32'h0, 32'(wr_cnt - w0));
		reg_read(REG_CTRL);
		check("op kept", 32'(OP_RESET), rd_val);
		reg_write(REG_CTRL, {28'h0, OP_ARRAY_READ});
		do_op(OP_RESET, 32'h0000_0000, 0);
		$display("test refuse done");
	endtask : t_refuse
	initial begin
		#(20 * 60000);
		error_cnt++;
		$display("unexpected watchdog: expected finish, seen hang");
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		#1 t_reset();
		t_array();
		t_guard();
		t_freeze();
		t_ecc_reset();
		t_refuse();
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
